// [mrf_regfile_ctrl.sv]
// register file with microcode/macro address selection and operand counters
`timescale 1ns/1ps
`include "mrf_defines.svh"

module mrf_regfile_ctrl
  import mrf_pkg::*;
(
  input  wire logic                                i_clk,
  input  wire logic                                i_reset,
  // control pipeline register slice, bits 91 down to 66
  input  wire logic [`MRF_CTL_HI:`MRF_CTL_LO]      i_ctl_word,
  // macro instruction operand fields and their load strobe
  input  wire logic                                i_macro_load,
  input  wire mrf_addr_t                           i_macro_a_operand,
  input  wire mrf_addr_t                           i_macro_b_operand,
  input  wire mrf_addr_t                           i_macro_c_operand,
  // floating point unit seed register output enable, active low
  input  wire logic                                i_fp_seed_drive_n,
  // write data for the two write ports
  input  wire mrf_word_t                           i_write_port1_data,
  input  wire mrf_word_t                           i_write_port2_data,
  // side port for software
  input  wire logic [`MRF_BUS_AW-1:0]              i_bus_addr,
  input  wire mrf_word_t                           i_bus_wdata,
  input  wire logic                                i_bus_wr,
  input  wire logic                                i_bus_rd,
  output mrf_word_t                                o_bus_rdata,
  // read operands, registered
  output mrf_word_t                                o_read_a_data,
  output mrf_word_t                                o_read_b_data,
  // resolved addresses
  output mrf_addr_t                                o_read_a_addr,
  output mrf_addr_t                                o_read_b_addr,
  output mrf_addr_t                                o_write_port1_addr,
  output mrf_addr_t                                o_write_port2_addr,
  // bus enables, all active low
  output logic                                     o_read_a_drive_n,
  output logic                                     o_d_to_a_xcvr_en_n,
  output logic                                     o_write_port1_en_n,
  output logic                                     o_write_port2_en_n,
  // counter values for observation
  output mrf_addr_t                                o_ctr_a,
  output mrf_addr_t                                o_ctr_b,
  output mrf_addr_t                                o_ctr_c
);

  // field extraction from the control word
  // every bit is one wire; what it means depends on the select bits
  logic       read_a_src_sel;
  logic       read_b_src_sel;
  mrf_addr_t  read_a_addr_field;
  mrf_addr_t  read_b_addr_field;
  mrf_addr_t  write_c_addr_field;
  mrf_wsrc_e  write_src;
  logic       second_write_addr_sel;
  logic       read_a_drive_n;
  logic       write_port1_en_n;
  logic       write_port2_en_n;

  // each bit keeps its single wiring; alternate meanings are decoded below
  assign read_a_src_sel        = i_ctl_word[`MRF_BIT_RD_A_SEL];
  assign read_b_src_sel        = i_ctl_word[`MRF_BIT_RD_B_SEL];
  assign read_a_addr_field     = i_ctl_word[`MRF_FLD_A_HI:`MRF_FLD_A_LO];
  assign read_b_addr_field     = i_ctl_word[`MRF_FLD_B_HI:`MRF_FLD_B_LO];
  assign write_c_addr_field    = i_ctl_word[`MRF_FLD_C_HI:`MRF_FLD_C_LO];
  assign write_src             = mrf_wsrc_e'(i_ctl_word[`MRF_FLD_WSRC_HI:`MRF_FLD_WSRC_LO]);
  assign second_write_addr_sel = i_ctl_word[`MRF_BIT_WR2_SEL];
  assign read_a_drive_n        = i_ctl_word[`MRF_BIT_RD_A_OE_N];
  assign write_port1_en_n      = i_ctl_word[`MRF_BIT_WR1_EN_N];
  assign write_port2_en_n      = i_ctl_word[`MRF_BIT_WR2_EN_N];

  // alternate meaning: address fields as counter controls
  // outside the alternate meaning the enable bit is only an address bit
  logic ctr_a_direction;
  logic ctr_a_step_en;
  logic ctr_b_direction;
  logic ctr_b_step_en;
  logic ctr_c_direction;
  logic ctr_c_step_en;
  logic c_field_is_ctl;

  // the C field turns into counter controls for any non-microcode source
  assign c_field_is_ctl = (write_src != MRF_WSRC_C_MICRO);

  // counter controls only take effect while the alternate meaning holds
  always_comb
  begin
    ctr_a_direction = read_a_addr_field[`MRF_ALT_DIR_BIT];
    ctr_a_step_en   = read_a_src_sel & read_a_addr_field[`MRF_ALT_EN_BIT];
    ctr_b_direction = read_b_addr_field[`MRF_ALT_DIR_BIT];
    ctr_b_step_en   = read_b_src_sel & read_b_addr_field[`MRF_ALT_EN_BIT];
    ctr_c_direction = write_c_addr_field[`MRF_ALT_DIR_BIT];
    ctr_c_step_en   = c_field_is_ctl & write_c_addr_field[`MRF_ALT_EN_BIT];
  end

  // side port decode
  // only the three counter offsets load; status and holes are ignored
  logic sw_wr_ctr_a;
  logic sw_wr_ctr_b;
  logic sw_wr_ctr_c;

  // a software write to a counter offset loads that counter
  always_comb
  begin
    sw_wr_ctr_a = 1'h0;
    sw_wr_ctr_b = 1'h0;
    sw_wr_ctr_c = 1'h0;
    if (i_bus_wr)
    begin
      case (i_bus_addr)
        `MRF_OFS_CTR_A: sw_wr_ctr_a = 1'h1;
        `MRF_OFS_CTR_B: sw_wr_ctr_b = 1'h1;
        `MRF_OFS_CTR_C: sw_wr_ctr_c = 1'h1;
        default:        sw_wr_ctr_c = 1'h0;
      endcase
    end
  end

  // macro operand counters, one per channel
  // load values and step controls are gathered per channel for the loop
  logic      ctr_load  [`MRF_CTR_COUNT];
  mrf_addr_t ctr_value [`MRF_CTR_COUNT];
  logic      ctr_step  [`MRF_CTR_COUNT];
  logic      ctr_down  [`MRF_CTR_COUNT];
  mrf_addr_t ctr_count [`MRF_CTR_COUNT];
  logic      sw_load   [`MRF_CTR_COUNT];
  mrf_addr_t macro_opnd[`MRF_CTR_COUNT];

  // per channel sources gathered into arrays
  assign sw_load[`MRF_CH_A]    = sw_wr_ctr_a;
  assign sw_load[`MRF_CH_B]    = sw_wr_ctr_b;
  assign sw_load[`MRF_CH_C]    = sw_wr_ctr_c;
  assign macro_opnd[`MRF_CH_A] = i_macro_a_operand;
  assign macro_opnd[`MRF_CH_B] = i_macro_b_operand;
  assign macro_opnd[`MRF_CH_C] = i_macro_c_operand;
  assign ctr_step[`MRF_CH_A]   = ctr_a_step_en;
  assign ctr_step[`MRF_CH_B]   = ctr_b_step_en;
  assign ctr_step[`MRF_CH_C]   = ctr_c_step_en;
  assign ctr_down[`MRF_CH_A]   = ctr_a_direction;
  assign ctr_down[`MRF_CH_B]   = ctr_b_direction;
  assign ctr_down[`MRF_CH_C]   = ctr_c_direction;

  genvar ch;
  generate
    for (ch = 0; ch < `MRF_CTR_COUNT; ch = ch + 1)
    begin : g_ctr
      // software write wins over a macro load, which wins over a step
      assign ctr_load[ch]  = sw_load[ch] | i_macro_load;
      assign ctr_value[ch] = sw_load[ch] ? i_bus_wdata[`MRF_ADDR_W-1:0] : macro_opnd[ch];

      mrf_operand_ctr u_ctr (
        .i_clk        (i_clk),
        .i_reset      (i_reset),
        .i_load       (ctr_load[ch]),
        .i_load_value (ctr_value[ch]),
        .i_step       (ctr_step[ch]),
        .i_down       (ctr_down[ch]),
        .o_count      (ctr_count[ch])
      );
    end
  endgenerate

  // counter values for observation
  assign o_ctr_a = ctr_count[`MRF_CH_A];
  assign o_ctr_b = ctr_count[`MRF_CH_B];
  assign o_ctr_c = ctr_count[`MRF_CH_C];

  // address multiplexers
  // all four addresses settle from the current word and counter values
  mrf_addr_t read_a_addr;
  mrf_addr_t read_b_addr;
  mrf_addr_t write_port1_addr;
  mrf_addr_t write_port2_addr;

  // read address A: counter when the select bit is high, field otherwise
  always_comb
  begin
    if (read_a_src_sel)
    begin
      read_a_addr = ctr_count[`MRF_CH_A];
    end
    else
    begin
      read_a_addr = read_a_addr_field;
    end
  end

  // read address B: counter when the select bit is high, field otherwise
  always_comb
  begin
    if (read_b_src_sel)
    begin
      read_b_addr = ctr_count[`MRF_CH_B];
    end
    else
    begin
      read_b_addr = read_b_addr_field;
    end
  end

  // first write port address from the two-bit source code
  always_comb
  begin
    case (write_src)
      MRF_WSRC_C_MICRO: write_port1_addr = write_c_addr_field;
      MRF_WSRC_A_OPND:  write_port1_addr = read_a_addr;
      MRF_WSRC_B_OPND:  write_port1_addr = read_b_addr;
      MRF_WSRC_C_CTR:   write_port1_addr = ctr_count[`MRF_CH_C];
      default:          write_port1_addr = write_c_addr_field;
    endcase
  end

  // second write port lets data enter while other work goes on
  always_comb
  begin
    if (second_write_addr_sel)
    begin
      write_port2_addr = ctr_count[`MRF_CH_C];
    end
    else
    begin
      write_port2_addr = write_c_addr_field;
    end
  end

  // resolved addresses out to the file pins and the status word
  assign o_read_a_addr      = read_a_addr;
  assign o_read_b_addr      = read_b_addr;
  assign o_write_port1_addr = write_port1_addr;
  assign o_write_port2_addr = write_port2_addr;

  // bus enables
  // read and write enables follow their pipeline bits with no decode; the transceiver enable also decodes the seed input
  // read port A onto the operand bus while bit 68 is low
  assign o_read_a_drive_n = read_a_drive_n;

  // transceiver only when neither the file nor the seed register drives
  assign o_d_to_a_xcvr_en_n = ~(read_a_drive_n & i_fp_seed_drive_n);

  // write enables pass straight through, active low
  assign o_write_port1_en_n = write_port1_en_n;
  assign o_write_port2_en_n = write_port2_en_n;

  // register file storage
  // sixty-four words with no reset; contents are undefined until written
  mrf_word_t file_mem [`MRF_DEPTH];
  logic      wr2_shadowed;

  // port two gives way when port one writes the same word in the same edge
  assign wr2_shadowed = !write_port1_en_n && (write_port1_addr == write_port2_addr);

  // two writes per edge into the array
  always_ff @(posedge i_clk)
  begin
    if (!write_port2_en_n && !wr2_shadowed)
    begin
      file_mem[write_port2_addr] <= i_write_port2_data;
    end
    if (!write_port1_en_n)
    begin
      file_mem[write_port1_addr] <= i_write_port1_data;
    end
  end

  // reads sample the old contents on the same edge as the write
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_read_a_data <= `MRF_WORD_ZERO;
      o_read_b_data <= `MRF_WORD_ZERO;
    end
    else
    begin
      o_read_a_data <= file_mem[read_a_addr];
      o_read_b_data <= file_mem[read_b_addr];
    end
  end

  // side port read data, one cycle after the strobe
  // zero outside that cycle so a stale word is never read twice
  mrf_word_t next_bus_rdata;

  // counters in the low bits, status word holds both write addresses
  always_comb
  begin
    next_bus_rdata = `MRF_WORD_ZERO;
    case (i_bus_addr)
      `MRF_OFS_CTR_A:
      begin
        next_bus_rdata[`MRF_ADDR_W-1:0] = ctr_count[`MRF_CH_A];
      end
      `MRF_OFS_CTR_B:
      begin
        next_bus_rdata[`MRF_ADDR_W-1:0] = ctr_count[`MRF_CH_B];
      end
      `MRF_OFS_CTR_C:
      begin
        next_bus_rdata[`MRF_ADDR_W-1:0] = ctr_count[`MRF_CH_C];
      end
      `MRF_OFS_STATUS:
      begin
        next_bus_rdata[`MRF_ADDR_W-1:0] = write_port1_addr;
        next_bus_rdata[`MRF_ST_WR2_LO +: `MRF_ADDR_W] = write_port2_addr;
      end
      default:
      begin
        next_bus_rdata = `MRF_WORD_ZERO;
      end
    endcase
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_bus_rdata <= `MRF_WORD_ZERO;
    end
    else if (i_bus_rd)
    begin
      o_bus_rdata <= next_bus_rdata;
    end
    else
    begin
      o_bus_rdata <= `MRF_WORD_ZERO;
    end
  end

endmodule

// [mrf_defines.svh]
// constants for the microcoded register file address control block
`ifndef MRF_DEFINES_SVH
`define MRF_DEFINES_SVH

// widths of the file, its addresses and the control word slice
`define MRF_ADDR_W        6
`define MRF_DATA_W        32
`define MRF_DEPTH         64
`define MRF_CTR_COUNT     3
`define MRF_CTL_HI        91
`define MRF_CTL_LO        66

// control pipeline bit positions
`define MRF_BIT_RD_A_SEL  91
`define MRF_FLD_A_HI      90
`define MRF_FLD_A_LO      85
`define MRF_BIT_RD_B_SEL  84
`define MRF_FLD_B_HI      83
`define MRF_FLD_B_LO      78
`define MRF_FLD_WSRC_HI   77
`define MRF_FLD_WSRC_LO   76
`define MRF_FLD_C_HI      75
`define MRF_FLD_C_LO      70
`define MRF_BIT_WR2_SEL   69
`define MRF_BIT_RD_A_OE_N 68
`define MRF_BIT_WR1_EN_N  67
`define MRF_BIT_WR2_EN_N  66

// alternate meaning of an address field: counter controls
`define MRF_ALT_DIR_BIT   1
`define MRF_ALT_EN_BIT    0

// counter channel numbers
`define MRF_CH_A          0
`define MRF_CH_B          1
`define MRF_CH_C          2

// side port register offsets and layout
`define MRF_BUS_AW        4
`define MRF_OFS_CTR_A     4'h0
`define MRF_OFS_CTR_B     4'h4
`define MRF_OFS_CTR_C     4'h8
`define MRF_OFS_STATUS    4'hC
`define MRF_ST_WR2_LO     8
`define MRF_CTR_RESET     6'h00
`define MRF_CTR_STEP      6'h01
`define MRF_WORD_ZERO     32'h0000_0000

`endif

// [mrf_pkg.sv]
// types shared by the register file address control block
`include "mrf_defines.svh"

package mrf_pkg;

  typedef logic [`MRF_ADDR_W-1:0] mrf_addr_t;
  typedef logic [`MRF_DATA_W-1:0] mrf_word_t;

  // source code of the first write port address
  typedef enum logic [1:0] {
    MRF_WSRC_C_MICRO = 2'h0,
    MRF_WSRC_A_OPND  = 2'h1,
    MRF_WSRC_B_OPND  = 2'h2,
    MRF_WSRC_C_CTR   = 2'h3
  } mrf_wsrc_e;

endpackage

// [mrf_operand_ctr.sv]
// one macro operand address counter: load, step up or step down
`timescale 1ns/1ps
`include "mrf_defines.svh"

module mrf_operand_ctr
  import mrf_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_reset,
  input  wire logic      i_load,
  input  wire mrf_addr_t i_load_value,
  input  wire logic      i_step,
  input  wire logic      i_down,
  output mrf_addr_t      o_count
);

  // load beats a step in the same cycle; counter wraps modulo depth
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_count <= `MRF_CTR_RESET;
    end
    else if (i_load)
    begin
      o_count <= i_load_value;
    end
    else if (i_step)
    begin
      if (i_down)
      begin
        o_count <= o_count - `MRF_CTR_STEP;
      end
      else
      begin
        o_count <= o_count + `MRF_CTR_STEP;
      end
    end
  end

endmodule

// [mrf_pipe_model.sv]
// control store pipeline register model driving the control word
`timescale 1ns/1ps
`include "mrf_defines.svh"

module mrf_pipe_model
  import mrf_pkg::*;
(
  input  wire logic                           i_clk,
  input  wire logic                           i_reset,
  input  wire logic [`MRF_CTL_HI:`MRF_CTL_LO] i_next_word,
  output logic      [`MRF_CTL_HI:`MRF_CTL_LO] o_ctl_word
);
  // idle word holds every active-low enable off
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_ctl_word <= 26'h0000007;
    else
      o_ctl_word <= i_next_word;
  end
endmodule

// [mrf_checker.sv]
// concurrent checks on the address control block ports
`timescale 1ns/1ps
`include "mrf_defines.svh"

module mrf_checker
  import mrf_pkg::*;
(
  input wire logic                           i_clk,
  input wire logic                           i_reset,
  input wire logic [`MRF_CTL_HI:`MRF_CTL_LO] i_ctl_word,
  input wire logic                           i_macro_load,
  input wire mrf_addr_t                      i_macro_a_operand,
  input wire logic                           i_fp_seed_drive_n,
  input wire logic [`MRF_BUS_AW-1:0]         i_bus_addr,
  input wire logic                           i_bus_wr,
  input wire mrf_addr_t                      o_read_a_addr,
  input wire mrf_addr_t                      o_read_b_addr,
  input wire mrf_addr_t                      o_write_port1_addr,
  input wire mrf_addr_t                      o_write_port2_addr,
  input wire logic                           o_read_a_drive_n,
  input wire logic                           o_d_to_a_xcvr_en_n,
  input wire logic                           o_write_port1_en_n,
  input wire logic                           o_write_port2_en_n,
  input wire mrf_addr_t                      o_ctr_a,
  input wire mrf_addr_t                      o_ctr_c
);
  mrf_addr_t wr1_exp;
  logic      busy_a;
  logic      busy_c;

  // expected first write address and counter overrides
  always_comb
  begin
    case (i_ctl_word[77:76])
      2'h0:    wr1_exp = i_ctl_word[75:70];
      2'h1:    wr1_exp = o_read_a_addr;
      2'h2:    wr1_exp = o_read_b_addr;
      default: wr1_exp = o_ctr_c;
    endcase
  end
  assign busy_a = i_macro_load || (i_bus_wr && i_bus_addr == 4'h0);
  assign busy_c = i_macro_load || (i_bus_wr && i_bus_addr == 4'h8);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  rd_a_src_a:
    assert property (o_read_a_addr == (i_ctl_word[91] ? o_ctr_a : i_ctl_word[90:85]))
    else $error("read A address source wrong");
  rd_b_src_a:
    assert property (!i_ctl_word[84] |-> o_read_b_addr == i_ctl_word[83:78])
    else $error("read B address not from field");
  wr1_src_a:
    assert property (o_write_port1_addr == wr1_exp)
    else $error("first write address source wrong");
  ctr_a_step_a:
    assert property (i_ctl_word[91] && i_ctl_word[85] && !busy_a |=> o_ctr_a ==
      ($past(i_ctl_word[86]) ? $past(o_ctr_a) - 6'h01 : $past(o_ctr_a) + 6'h01))
    else $error("counter A step wrong");
  ctr_a_hold_a:
    assert property (!i_ctl_word[91] && !busy_a |=> $stable(o_ctr_a))
    else $error("counter A moved under microcode address");
  ctr_c_step_a:
    assert property (i_ctl_word[77:76] != 2'h0 && i_ctl_word[70] && !busy_c |=> o_ctr_c ==
      ($past(i_ctl_word[71]) ? $past(o_ctr_c) - 6'h01 : $past(o_ctr_c) + 6'h01))
    else $error("counter C step wrong");
  ctr_c_hold_a:
    assert property (i_ctl_word[77:76] == 2'h0 && !busy_c |=> $stable(o_ctr_c))
    else $error("counter C moved under microcode address");
  wr2_src_a:
    assert property (o_write_port2_addr == (i_ctl_word[69] ? o_ctr_c : i_ctl_word[75:70]))
    else $error("second write address source wrong");
  bus_drive_a:
    assert property (o_read_a_drive_n == i_ctl_word[68] &&
      o_d_to_a_xcvr_en_n == !(i_ctl_word[68] && i_fp_seed_drive_n))
    else $error("A bus enables wrong");
  wr_en_a:
    assert property (o_write_port1_en_n == i_ctl_word[67] && o_write_port2_en_n == i_ctl_word[66])
    else $error("write enables wrong");
  ctr_load_a:
    assert property (i_macro_load && !i_bus_wr |=> o_ctr_a == $past(i_macro_a_operand))
    else $error("counter A load wrong");
endmodule

bind mrf_regfile_ctrl mrf_checker mrf_checker_inst (
  .i_clk, .i_reset, .i_ctl_word, .i_macro_load, .i_macro_a_operand, .i_fp_seed_drive_n,
  .i_bus_addr, .i_bus_wr, .o_read_a_addr, .o_read_b_addr, .o_write_port1_addr,
  .o_write_port2_addr, .o_read_a_drive_n, .o_d_to_a_xcvr_en_n, .o_write_port1_en_n,
  .o_write_port2_en_n, .o_ctr_a, .o_ctr_c
);

// [tb.sv]
// self-checking bench for the register file address control block
`timescale 1ns/1ps
`include "mrf_defines.svh"

module tb
  import mrf_pkg::*;
;
  logic                           i_clk = 1'h0;
  logic                           i_reset = 1'h1;
  logic [`MRF_CTL_HI:`MRF_CTL_LO] nw = 26'h0000007;
  wire  [`MRF_CTL_HI:`MRF_CTL_LO] i_ctl_word;
  logic                           i_macro_load = 1'h0;
  logic                           i_fp_seed_drive_n = 1'h1;
  mrf_addr_t                      i_macro_a_operand = 6'h00;
  mrf_addr_t                      i_macro_b_operand = 6'h00;
  mrf_addr_t                      i_macro_c_operand = 6'h00;
  mrf_word_t                      i_write_port1_data = 32'h0;
  mrf_word_t                      i_write_port2_data = 32'h0;
  logic [3:0]                     i_bus_addr = 4'h0;
  mrf_word_t                      i_bus_wdata = 32'h0;
  logic                           i_bus_wr = 1'h0;
  logic                           i_bus_rd = 1'h0;
  mrf_word_t                      o_bus_rdata, o_read_a_data, o_read_b_data;
  mrf_addr_t                      o_read_a_addr, o_read_b_addr, o_ctr_a, o_ctr_b, o_ctr_c;
  mrf_addr_t                      o_write_port1_addr, o_write_port2_addr;
  logic                           o_read_a_drive_n, o_d_to_a_xcvr_en_n;
  logic                           o_write_port1_en_n, o_write_port2_en_n;
  int                             fails = 0;
  int                             comparisons = 0;
  logic [5:0]                     cv [3] = '{6'h05, 6'h3F, 6'h21};
  logic [5:0]                     w1e [4] = '{6'h14, 6'h2A, 6'h3F, 6'h21};

  mrf_pipe_model mrf_pipe_model_inst (.i_clk, .i_reset, .i_next_word(nw), .o_ctl_word(i_ctl_word));
  mrf_regfile_ctrl mrf_regfile_ctrl_inst (
    .i_clk, .i_reset, .i_ctl_word, .i_macro_load, .i_macro_a_operand, .i_macro_b_operand,
    .i_macro_c_operand, .i_fp_seed_drive_n, .i_write_port1_data, .i_write_port2_data,
    .i_bus_addr, .i_bus_wdata, .i_bus_wr, .i_bus_rd, .o_bus_rdata, .o_read_a_data,
    .o_read_b_data, .o_read_a_addr, .o_read_b_addr, .o_write_port1_addr,
    .o_write_port2_addr, .o_read_a_drive_n, .o_d_to_a_xcvr_en_n, .o_write_port1_en_n,
    .o_write_port2_en_n, .o_ctr_a, .o_ctr_b, .o_ctr_c);

  // 250 MHz clock
  always #2 i_clk = ~i_clk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // control word reaches the block on the edge the model takes it, one edge after the task drives it
  task automatic ctl(input logic [91:66] v);
    @(posedge i_clk);
    nw <= v;
    @(posedge i_clk);
    #1;
  endtask

  task automatic bwr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_bus_addr <= a;
    i_bus_wdata <= d;
    i_bus_wr <= 1'h1;
    @(posedge i_clk);
    i_bus_wr <= 1'h0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_bus_addr <= a;
    i_bus_rd <= 1'h1;
    @(posedge i_clk);
    i_bus_rd <= 1'h0;
    #1;
    chk(n, e, o_bus_rdata);
  endtask

  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'h0;
    #1;
    chk("ctr_c reset", 32'h0, 32'(o_ctr_c));
    bwr(4'hC, 32'hFFFF_FFFF);
    rchk("unmapped", 4'h2, 32'h0);
    rchk("status ro", 4'hC, 32'h0);
    for (int k = 0; k < 3; k++)
      bwr(4'(k * 4), 32'(cv[k]));
    for (int k = 0; k < 3; k++)
      rchk("ctr bus", 4'(k * 4), 32'(cv[k]));
    // every write source code, both second port selects
    for (int s = 0; s < 4; s++)
    begin
      ctl({1'h0, 6'h2A, 1'h1, 6'h00, 2'(s), 6'h14, s[0], 3'h7});
      chk("read a addr", 32'h2A, 32'(o_read_a_addr));
      chk("read b addr", 32'h3F, 32'(o_read_b_addr));
      chk("wr1 addr", 32'(w1e[s]), 32'(o_write_port1_addr));
      chk("ctr_c held", 32'h21, 32'(o_ctr_c));
      rchk("status", 4'hC, {18'h0, s[0] ? 6'h21 : 6'h14, 2'h0, w1e[s]});
    end
    // every enable combination with the seed output
    for (int k = 0; k < 16; k++)
    begin
      @(posedge i_clk);
      i_fp_seed_drive_n <= k[3];
      ctl({23'h0, 3'(k)});
      chk("a drive", 32'(k[2]), 32'(o_read_a_drive_n));
      chk("xcvr", 32'(!(k[2] && k[3])), 32'(o_d_to_a_xcvr_en_n));
      chk("wr en", 32'(k[1:0]), {30'h0, o_write_port1_en_n, o_write_port2_en_n});
    end
    // two steps each: A and B up with B wrapping, C down
    ctl({1'h1, 6'h01, 1'h1, 6'h01, 2'h3, 6'h03, 1'h0, 3'h7});
    ctl(26'h0000007);
    chk("ctr_a up", 32'h07, 32'(o_ctr_a));
    chk("ctr_b wrap", 32'h01, 32'(o_ctr_b));
    chk("ctr_c down", 32'h1F, 32'(o_ctr_c));
    // A down twice; B and C enable bits set but outside their alternate meaning
    ctl({1'h1, 6'h03, 1'h0, 6'h01, 2'h0, 6'h01, 1'h0, 3'h7});
    ctl(26'h0000007);
    chk("ctr_a down", 32'h05, 32'(o_ctr_a));
    chk("ctr_b held", 32'h01, 32'(o_ctr_b));
    chk("ctr_c held", 32'h1F, 32'(o_ctr_c));
    // fill two places, then read both while overwriting one
    @(posedge i_clk);
    i_write_port1_data <= 32'hA5A5_0001;
    i_write_port2_data <= 32'h5A5A_0002;
    ctl({16'h0, 6'h10, 1'h1, 3'h4});
    ctl(26'h0000007);
    @(posedge i_clk);
    i_write_port1_data <= 32'hA5A5_0003;
    ctl({1'h0, 6'h10, 1'h0, 6'h1F, 2'h0, 6'h10, 1'h0, 3'h1});
    @(posedge i_clk);
    #1;
    chk("read a old", 32'hA5A5_0001, o_read_a_data);
    chk("read b port2", 32'h5A5A_0002, o_read_b_data);
    @(posedge i_clk);
    #1;
    chk("read a new", 32'hA5A5_0003, o_read_a_data);
    ctl(26'h0000007);
    // macro operand load
    @(posedge i_clk);
    i_macro_load <= 1'h1;
    i_macro_a_operand <= 6'h0A;
    i_macro_b_operand <= 6'h0B;
    i_macro_c_operand <= 6'h0C;
    @(posedge i_clk);
    i_macro_load <= 1'h0;
    #1;
    chk("load", 32'h000A_0B0C, {8'h0, 2'h0, o_ctr_a, 2'h0, o_ctr_b, 2'h0, o_ctr_c});
    summarize();
  end
endmodule
